//--- rtl/adc_cfg_pkg.sv
// Constants for the converter configuration register bank
// Contract
// (R01) Conversion control at 03h resets 038Eh
// (R02) Bit 9 enables second channel
// (R03) Bit 8 enables first channel
// (R04) Bit 7 selects internal or external clock
// (R05) Oversampling ratio is 128 shifted by code
// (R06) Power mode: 00 vlow, 01 low, 1x hires
// (R07) Gain register at 04h resets 0000h
// (R08) Bits 6:4 give second channel gain
// (R09) Bits 2:0 give first channel gain
// (R10) Chop config at 06h resets 0600h
// (R11) Chop delay code gives modulator periods
// (R12) Bit 8 turns chop mode on
// (R13) Channel configs at 09h, 0Eh reset 0000h
// (R14) First channel input route, four ways
// (R15) Read-only reserved bits read zero
// (R16) Second channel input route, same encoding
// (R17) Host writes zero to reserved bits
package adc_cfg_pkg;
  // ************************************************
  // Register offsets (word index, byte address = index)
  // ************************************************
  localparam logic [7:0] conv_ctrl_off = 8'h03;
  localparam logic [7:0] gain_off = 8'h04;
  localparam logic [7:0] chop_off = 8'h06;
  localparam logic [7:0] first_channel_input_config_off = 8'h09;
  localparam logic [7:0] second_channel_input_config_off = 8'h0e;
  // ************************************************
  // Reset values and writable masks
  // ************************************************
  localparam logic [15:0] conv_ctrl_rst = 16'h038e;
  localparam logic [15:0] gain_rst = 16'h0000;
  localparam logic [15:0] chop_rst = 16'h0600;
  localparam logic [15:0] ch_cfg_rst = 16'h0000;
  localparam logic [15:0] conv_ctrl_wmask = 16'h03ff;
  localparam logic [15:0] ch_cfg_wmask = 16'hffc7;
  localparam logic [15:0] full_wmask = 16'hffff;
  // ************************************************
  // Field positions
  // ************************************************
  localparam int second_channel_enable_bit = 9;
  localparam int first_channel_enable_bit = 8;
  localparam int clk_sel_bit = 7;
  localparam int osr_lsb = 2;
  localparam int pwr_lsb = 0;
  localparam int gain1_lsb = 4;
  localparam int gain0_lsb = 0;
  localparam int dly_lsb = 9;
  localparam int chop_en_bit = 8;
  localparam int route_lsb = 0;
  // ************************************************
  // Decoded values
  // ************************************************
  localparam logic [14:0] osr_base = 15'd128;
  localparam logic [16:0] dly_base = 17'd2;
  localparam logic [3:0] dly_missing_code = 4'he;
  localparam logic [3:0] dly_top_code = 4'hf;
  localparam logic [16:0] dly_top = 17'h10000;
  typedef enum logic [2:0] {
    pwr_very_low = 3'b001,
    pwr_low = 3'b010,
    pwr_high_res = 3'b100
  } pwr_mode_e;
  typedef enum logic [3:0] {
    route_ext_pair = 4'b0001,
    route_shorted = 4'b0010,
    route_test_pos = 4'b0100,
    route_test_neg = 4'b1000
  } input_route_e;
endpackage : adc_cfg_pkg

//--- rtl/adc_config_register_bank.sv
// Configuration register bank of a two-channel converter
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // Channel enables and clocking
  output logic second_channel_enable_out,
  output logic first_channel_enable_out,
  output logic ext_clock_select_out,
  output logic [2:0] oversampling_ratio_code_out,
  output logic [14:0] oversampling_ratio_out,
  output adc_cfg_pkg::pwr_mode_e power_mode_out,
  // Amplifier gains
  output logic [2:0] second_channel_gain_code_out,
  output logic [2:0] first_channel_gain_code_out,
  output logic [7:0] second_channel_gain_out,
  output logic [7:0] first_channel_gain_out,
  // Global chop
  output logic chop_mode_enable_out,
  output logic [3:0] chop_delay_code_out,
  output logic [16:0] chop_delay_periods_out,
  // Input routing
  output adc_cfg_pkg::input_route_e first_channel_input_route_out,
  output adc_cfg_pkg::input_route_e second_channel_input_route_out
);
  import adc_cfg_pkg::*;

  // ************************************************
  // Decode helpers
  // ************************************************
  function automatic input_route_e route_of(input logic [1:0] code);
    input_route_e r;
    r = route_ext_pair;
    case (code)
      2'b00: r = route_ext_pair;
      2'b01: r = route_shorted;
      2'b10: r = route_test_pos;
      default: r = route_test_neg;
    endcase
    return r;
  endfunction : route_of

  function automatic logic [7:0] gain_of(input logic [2:0] code);
    return 8'h01 << code;
  endfunction : gain_of

  // ************************************************
  // Address decode
  // ************************************************
  wire logic hit_conv = (addr_in == conv_ctrl_off);
  wire logic hit_gain = (addr_in == gain_off);
  wire logic hit_chop = (addr_in == chop_off);
  wire logic hit_ch0 = (addr_in == first_channel_input_config_off);
  wire logic hit_ch1 = (addr_in == second_channel_input_config_off);

  logic [15:0] conv_q;
  logic [15:0] gain_q;
  logic [15:0] chop_q;
  logic [15:0] ch0_q;
  logic [15:0] ch1_q;

  // ************************************************
  // Register storage
  // ************************************************
  // (R01) conversion control reset
  cfg_reg16 #(.rst_val(conv_ctrl_rst), .wmask(conv_ctrl_wmask)) u_conv (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr_in && hit_conv),
    .data_in(wdata_in),
    .value_out(conv_q)
  );
  // (R07) gain register reset
  cfg_reg16 #(.rst_val(gain_rst), .wmask(full_wmask)) u_gain (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr_in && hit_gain),
    .data_in(wdata_in),
    .value_out(gain_q)
  );
  // (R10) chop config reset
  cfg_reg16 #(.rst_val(chop_rst), .wmask(full_wmask)) u_chop (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr_in && hit_chop),
    .data_in(wdata_in),
    .value_out(chop_q)
  );
  // (R13) channel config resets
  cfg_reg16 #(.rst_val(ch_cfg_rst), .wmask(ch_cfg_wmask)) u_ch0 (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr_in && hit_ch0),
    .data_in(wdata_in),
    .value_out(ch0_q)
  );
  cfg_reg16 #(.rst_val(ch_cfg_rst), .wmask(ch_cfg_wmask)) u_ch1 (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_in(wr_in && hit_ch1),
    .data_in(wdata_in),
    .value_out(ch1_q)
  );

  // ************************************************
  // Read path
  // ************************************************
  // (R15) reserved read-only bits masked
  wire logic [15:0] nxt_rdata = hit_conv ? conv_q :
                                hit_gain ? gain_q :
                                hit_chop ? chop_q :
                                hit_ch0 ? ch0_q :
                                hit_ch1 ? ch1_q : 16'h0000;
  logic [15:0] rdata_ff;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 16'h0000;
    end else if (rd_in) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 16'h0000;
    end
  end
  assign rdata_out = rdata_ff;

  // ************************************************
  // Field decode
  // ************************************************
  // (R02) second channel enable
  assign second_channel_enable_out = conv_q[second_channel_enable_bit];
  // (R03) first channel enable
  assign first_channel_enable_out = conv_q[first_channel_enable_bit];
  // (R04) clock source select
  assign ext_clock_select_out = conv_q[clk_sel_bit];
  // (R05) oversampling ratio
  assign oversampling_ratio_code_out = conv_q[osr_lsb +: 3];
  assign oversampling_ratio_out = osr_base << oversampling_ratio_code_out;
  // (R06) power mode, 11 aliases 10
  assign power_mode_out = conv_q[pwr_lsb + 1] ? pwr_high_res :
                          conv_q[pwr_lsb] ? pwr_low : pwr_very_low;
  // (R08) second channel gain
  assign second_channel_gain_code_out = gain_q[gain1_lsb +: 3];
  assign second_channel_gain_out = gain_of(second_channel_gain_code_out);
  // (R09) first channel gain
  assign first_channel_gain_code_out = gain_q[gain0_lsb +: 3];
  assign first_channel_gain_out = gain_of(first_channel_gain_code_out);
  // (R12) chop mode enable
  assign chop_mode_enable_out = chop_q[chop_en_bit];
  // (R11) chop delay; unlisted code 1110 taken as 65536 too
  assign chop_delay_code_out = chop_q[dly_lsb +: 4];
  assign chop_delay_periods_out = (chop_delay_code_out >= dly_missing_code) ? dly_top :
                                  (dly_base << chop_delay_code_out);
  // (R14) first channel routing
  assign first_channel_input_route_out = route_of(ch0_q[route_lsb +: 2]);
  // (R16) second channel routing
  assign second_channel_input_route_out = route_of(ch1_q[route_lsb +: 2]);

  // ************************************************
  // Checks
  // ************************************************
  conv_reset_a: assert property (@(posedge clk_in) $rose(rst_n_in) |-> conv_q == conv_ctrl_rst) // (R01)
    else $error("conversion control not at reset value");
  ch1_enable_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // (R02)
    (wr_in && hit_conv) |=> second_channel_enable_out == $past(wdata_in[second_channel_enable_bit]))
    else $error("second channel enable did not follow write");
  ch0_enable_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // (R03)
    (wr_in && hit_conv) |=> first_channel_enable_out == $past(wdata_in[first_channel_enable_bit]))
    else $error("first channel enable did not follow write");
  osr_value_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // (R05)
    (wr_in && hit_conv && wdata_in[4:2] == 3'b111) |=> oversampling_ratio_out == 15'd16384)
    else $error("oversampling ratio wrong for top code");
  pwr_alias_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // (R06)
    conv_q[1] |-> power_mode_out == pwr_high_res)
    else $error("power mode not high resolution");
  gain_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // (R08)
    (wr_in && hit_gain) |=> second_channel_gain_out == (8'h01 << $past(wdata_in[6:4])))
    else $error("second channel gain wrong");
  chop_delay_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // (R11)
    chop_delay_code_out == 4'h3 |-> chop_delay_periods_out == 17'd16)
    else $error("chop delay decode wrong");
  chop_top_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // (R11)
    chop_delay_code_out == dly_top_code |-> chop_delay_periods_out == 17'h10000)
    else $error("chop delay top code wrong");
  // Channel configs keep writable reserved bits above, so only 5:3 are checked there
  reserved_conv_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // (R15)
    (rd_in && hit_conv) |=> rdata_out[15:10] == 6'h00)
    else $error("conversion control reserved bits not zero");
  reserved_chan_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // (R15)
    (rd_in && (hit_ch0 || hit_ch1)) |=> rdata_out[5:3] == 3'b000)
    else $error("channel config reserved bits not zero");
  route_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // (R14)
    (wr_in && hit_ch0 && wdata_in[1:0] == 2'b01) |=> first_channel_input_route_out == route_shorted)
    else $error("first channel route wrong");
endmodule : adc_config_register_bank
`default_nettype wire

//--- rtl/cfg_reg16.sv
// One 16-bit configuration register with writable mask
`timescale 1ns/1ps
`default_nettype none
module cfg_reg16 #(
  parameter logic [15:0] rst_val = 16'h0000,
  parameter logic [15:0] wmask = 16'hffff
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Write port
  input wire logic wr_in,
  input wire logic [15:0] data_in,
  // Stored value
  output logic [15:0] value_out
);
  logic [15:0] val_ff;
  wire logic [15:0] nxt_val = (data_in & wmask) | (val_ff & ~wmask);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      val_ff <= rst_val;
    end else if (wr_in) begin
      val_ff <= nxt_val;
    end
  end
  // Read-only bits held at zero regardless of the stored value
  assign value_out = val_ff & wmask;
endmodule : cfg_reg16
`default_nettype wire

//--- test/adc_config_register_bank_test.sv
// Self-checking bench for the converter configuration register bank
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank_test;
  import adc_cfg_pkg::*;
  // ********************************
  // Stimulus, outputs and bookkeeping
  // ********************************
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rdata_out;
  logic en1, en0, ext_clk, chop_en;
  logic [2:0] osr_code, g1_code, g0_code;
  logic [14:0] osr;
  logic [7:0] g1, g0;
  logic [3:0] dly_code;
  logic [16:0] dly;
  pwr_mode_e pwr;
  input_route_e route0, route1;
  int miscompares = 0;
  int checks_done = 0;
  logic [31:0] lfsr_state = 32'ha5e7;
  logic [15:0] d;
  logic [15:0] m [0:255];
  logic [7:0] regs [0:4] = '{8'h03, 8'h04, 8'h06, 8'h09, 8'h0e};

  always #10 clk_in = ~clk_in;

  adc_config_register_bank adc_config_register_bank_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .second_channel_enable_out(en1), .first_channel_enable_out(en0), .ext_clock_select_out(ext_clk),
    .oversampling_ratio_code_out(osr_code), .oversampling_ratio_out(osr), .power_mode_out(pwr),
    .second_channel_gain_code_out(g1_code), .first_channel_gain_code_out(g0_code),
    .second_channel_gain_out(g1), .first_channel_gain_out(g0), .chop_mode_enable_out(chop_en),
    .chop_delay_code_out(dly_code), .chop_delay_periods_out(dly),
    .first_channel_input_route_out(route0), .second_channel_input_route_out(route1)
  );
  // ********************************
  // Helpers
  // ********************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
  endfunction : lfsr_next

  // Only stored bits change; read-only and unmapped places stay zero
  function automatic logic [15:0] wmask(input logic [7:0] a);
    case (a)
      8'h03: return 16'h03ff;
      8'h04, 8'h06: return 16'hffff;
      8'h09, 8'h0e: return 16'hffc7;
      default: return 16'h0000;
    endcase
  endfunction : wmask

  task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic do_reset;
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    foreach (m[i]) m[i] = 16'h0000;
    m[8'h03] = 16'h038e;
    m[8'h06] = 16'h0600;
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    m[a] = (m[a] & ~wmask(a)) | (v & wmask(a));
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk({1'b0, rdata_out}, {1'b0, m[a]}, "read data");
  endtask : rd

  task automatic chk_fields;
    #1;
    chk(en1, m[3][9], "ch1 enable");
    chk(en0, m[3][8], "ch0 enable");
    chk(ext_clk, m[3][7], "clock select");
    chk(osr_code, m[3][4:2], "osr code");
    chk(osr, 15'h80 << m[3][4:2], "osr");
    chk(pwr, m[3][1:0] == 2'h0 ? pwr_very_low : (m[3][1:0] == 2'h1 ? pwr_low : pwr_high_res), "power");
    chk(g1_code, m[4][6:4], "gain1 code");
    chk(g1, 8'h1 << m[4][6:4], "gain1");
    chk(g0_code, m[4][2:0], "gain0 code");
    chk(g0, 8'h1 << m[4][2:0], "gain0");
    chk(chop_en, m[6][8], "chop enable");
    chk(dly_code, m[6][12:9], "delay code");
    chk(dly, m[6][12:9] >= 4'he ? 17'h10000 : 17'h2 << m[6][12:9], "delay");
    chk(route0, 4'h1 << m[9][1:0], "route0");
    chk(route1, 4'h1 << m[14][1:0], "route1");
  endtask : chk_fields

  task automatic end_of_test;
    $display("Counts: %0d checks, %0d mismatches", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  // ********************************
  // Tests
  // ********************************
  initial begin
    do_reset;
    foreach (regs[i]) rd(regs[i]);
    chk_fields;
    $display("test reset values done");
    // Every code of every field; writable reserved bits left zero
    for (int k = 0; k < 16; k++) begin
      lfsr_state = lfsr_next(lfsr_state);
      d = lfsr_state[15:0];
      wr(8'h03, (d & 16'hff80) | {11'h0, k[2:0], k[1:0]});
      wr(8'h04, {9'h0, k[2:0], 1'b0, ~k[2:0]});
      wr(8'h06, {3'h0, k[3:0], d[0], 8'h00});
      wr(8'h09, (d & 16'h0038) | {14'h0, k[1:0]});
      wr(8'h0e, (d & 16'h0038) | {14'h0, ~k[1:0]});
      chk_fields;
      foreach (regs[j]) rd(regs[j]);
    end
    $display("test field codes done");
    // Unmapped places neither store nor disturb the bank
    wr(8'h05, lfsr_state[31:16]);
    wr(8'hff, 16'hffff);
    rd(8'h05);
    foreach (regs[i]) rd(regs[i]);
    $display("test unmapped done");
    // Write then read with no gap, then idle read data
    @(posedge clk_in);
    addr_in <= 8'h04;
    wdata_in <= 16'h0070;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    m[4] = 16'h0070;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, 16'h0070, "back to back read");
    chk(g1, 8'h80, "gain1 top code");
    @(posedge clk_in);
    #1;
    chk(rdata_out, 16'h0000, "idle read data");
    $display("test back to back done");
    do_reset;
    foreach (regs[i]) rd(regs[i]);
    chk_fields;
    $display("test second reset done");
    end_of_test;
  end

  // Roughly 370 cycles expected; over five times that means a hang
  initial begin
    #(20 * 2000);
    miscompares++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_of_test;
  end
endmodule : adc_config_register_bank_test
`default_nettype wire
